// ### core/sogate_pkg.sv
package sogate_pkg;

   // Diagnostic codes, one per state
   localparam logic [15:0] DIAG_IDLE     = 16'h0000;
   localparam logic [15:0] DIAG_INIT     = 16'h8001;
   localparam logic [15:0] DIAG_SAFE     = 16'h8002;
   localparam logic [15:0] DIAG_LOCK     = 16'h8003;
   localparam logic [15:0] DIAG_OUT_DIS  = 16'h8010;
   localparam logic [15:0] DIAG_OUT_EN   = 16'h8000;
   localparam logic [15:0] DIAG_RST_ERR1 = 16'hC001;
   localparam logic [15:0] DIAG_RST_ERR2 = 16'hC002;
   localparam logic [15:0] DIAG_CTL_ERR  = 16'hC010;
   localparam logic [15:0] DIAG_INIT_ERR = 16'hC111;
   localparam logic [15:0] DIAG_LOCK_ERR = 16'hC211;

   // AXI4-Lite register byte offsets
   localparam logic [3:0] OFS_CTRL   = 4'h0;
   localparam logic [3:0] OFS_STATUS = 4'h4;
   localparam logic [3:0] OFS_IRQ_ST = 4'h8;
   localparam logic [3:0] OFS_IRQ_EN = 4'hC;
   localparam logic [3:0] OFS_IRQ_CL = 4'h8;

   // Control register fields
   localparam int CTRL_ENABLE  = 0;
   localparam int CTRL_STATIC  = 1;
   localparam int CTRL_STARTUP = 2;
   localparam int CTRL_AUTO    = 3;
   localparam logic [3:0] CTRL_RESET_VAL = 4'h0;

   // Interrupt event bits
   localparam int IRQ_ERROR  = 0;
   localparam int IRQ_OUT_EN = 1;
   localparam int IRQ_OUT_DN = 2;
   localparam int IRQ_NUM    = 3;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // One-hot state codes
   typedef enum logic [10:0] {
      ST_IDLE     = 11'h001,
      ST_INIT     = 11'h002,
      ST_SAFE     = 11'h004,
      ST_LOCK     = 11'h008,
      ST_OUT_DIS  = 11'h010,
      ST_OUT_EN   = 11'h020,
      ST_RST_ERR1 = 11'h040,
      ST_RST_ERR2 = 11'h080,
      ST_CTL_ERR  = 11'h100,
      ST_INIT_ERR = 11'h200,
      ST_LOCK_ERR = 11'h400
   } sogate_state_t;

endpackage : sogate_pkg

// ### core/sogate_sync_if.sv
`timescale 1ns/1ns
// Synchronised pin levels, with previous values of request and reset
interface sogate_sync_if;
   logic permit;
   logic request;
   logic reset;
   logic request_prev;
   logic reset_prev;
   modport src (output permit, request, reset, request_prev, reset_prev);
   modport dst (input  permit, request, reset, request_prev, reset_prev);
endinterface : sogate_sync_if

// ### core/sogate_sync.sv
`timescale 1ns/1ns
module sogate_sync (
   // Clock and reset
   input  wire logic    clk,
   input  wire logic    rst,
   // Raw pins
   input  wire logic    permit_pin,
   input  wire logic    request_pin,
   input  wire logic    reset_pin,
   // Synchronised levels
   sogate_sync_if.src   sync
);
   logic [2:0] meta_reg;
   logic [2:0] stable_reg;
   logic [1:0] prev_reg;

   // Two flops per pin, then one more on request and reset for edge history
   always_ff @(posedge clk) begin
      if (rst) begin
         meta_reg   <= 3'h0;
         stable_reg <= 3'h0;
         prev_reg   <= 2'h0;
      end else begin
         meta_reg   <= {reset_pin, request_pin, permit_pin};
         stable_reg <= meta_reg;
         prev_reg   <= stable_reg[2:1];
      end
   end

   assign sync.permit       = stable_reg[0];
   assign sync.request      = stable_reg[1];
   assign sync.reset        = stable_reg[2];
   assign sync.request_prev = prev_reg[0];
   assign sync.reset_prev   = prev_reg[1];
endmodule : sogate_sync

// ### core/sogate_top.sv
// The AXI4-Lite interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ns
// Behaviour
// - Stuck-high reset, stuck-high request or miswiring lead to an error.
// - Every error state holds the actuator output off.
// - Reset-type errors are left only once reset is driven low.
// - The control error is left only once the request is driven low.
// - A reset rising edge clears the startup inhibit in init or lock.
// - Reset already high on entering init gives code C001.
// - Reset already high on entering lock gives code C002.
// - Request high unexpectedly while output disabled gives code C010.
// - Reset and request rising together in init give code C111.
// - Reset and request rising together in lock give code C211.
// - Enable low sends the block to idle from any state, first priority.
// - Enabling with startup clear off enters init, code 8001.
// - Permit back with manual restart waits in lock, code 8003.
// - Static option lets a held request enable the output.
module sogate_top
   import sogate_pkg::*;
(
   // Clock and reset
   input  wire logic        CORE_CLK,
   input  wire logic        RST,
   // Gate pins
   input  wire logic        SAFETY_PERMIT_IN,
   input  wire logic        PROCESS_REQUEST,
   input  wire logic        RESET_IN,
   output logic             SAFE_ACTUATOR_OUT,
   output logic             READY,
   output logic             ERROR,
   output logic [15:0]      DIAGNOSTIC_CODE,
   output logic             IRQ,
   // AXI4-Lite write address
   input  wire logic [3:0]  AWADDR,
   input  wire logic        AWVALID,
   output logic             AWREADY,
   // AXI4-Lite write data
   input  wire logic [31:0] WDATA,
   input  wire logic [3:0]  WSTRB,
   input  wire logic        WVALID,
   output logic             WREADY,
   // AXI4-Lite write response
   output logic [1:0]       BRESP,
   output logic             BVALID,
   input  wire logic        BREADY,
   // AXI4-Lite read address
   input  wire logic [3:0]  ARADDR,
   input  wire logic        ARVALID,
   output logic             ARREADY,
   // AXI4-Lite read data
   output logic [31:0]      RDATA,
   output logic [1:0]       RRESP,
   output logic             RVALID,
   input  wire logic        RREADY
);

   sogate_sync_if sync ();
   sogate_state_t state_reg, state_next;
   logic [3:0]  ctrl_reg;
   logic [2:0]  irq_st_reg, irq_st_next;
   logic [2:0]  irq_en_reg;
   logic        entry_reg;
   logic        aw_got, w_got;
   logic [3:0]  aw_addr_reg;
   logic [31:0] w_data_reg;
   logic [3:0]  w_strb_reg;
   logic [15:0] diag_next;

   ////////////////////////////////////////////////////////////////////////
   // Input synchroniser and edge history
   sogate_sync sogate_sync_i (
      .clk         (CORE_CLK),
      .rst         (RST),
      .permit_pin  (SAFETY_PERMIT_IN),
      .request_pin (PROCESS_REQUEST),
      .reset_pin   (RESET_IN),
      .sync        (sync)
   );

   ////////////////////////////////////////////////////////////////////////
   // Control bits and edge decode
   wire enable      = ctrl_reg[CTRL_ENABLE];
   wire static_opt  = ctrl_reg[CTRL_STATIC];
   wire startup_clr = ctrl_reg[CTRL_STARTUP];
   wire auto_rst    = ctrl_reg[CTRL_AUTO];
   wire rst_rise    = sync.reset & ~sync.reset_prev;
   wire req_rise    = sync.request & ~sync.request_prev;
   wire both_rise   = rst_rise & req_rise;
   // Level high on entry without a seen edge means stuck or miswired
   wire rst_stuck   = entry_reg & sync.reset & ~rst_rise;
   wire req_go      = static_opt ? sync.request : req_rise;

   ////////////////////////////////////////////////////////////////////////
   // Gate state machine
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            if (enable)
               state_next = startup_clr ? ST_OUT_DIS : ST_INIT;
         end
         ST_INIT: begin
            if (both_rise)
               state_next = ST_INIT_ERR;
            else if (rst_stuck)
               state_next = ST_RST_ERR1;
            else if (rst_rise)
               state_next = ST_OUT_DIS;
         end
         ST_SAFE: begin
            if (sync.permit)
               state_next = auto_rst ? ST_OUT_DIS : ST_LOCK;
         end
         ST_LOCK: begin
            if (!sync.permit)
               state_next = ST_SAFE;
            else if (both_rise)
               state_next = ST_LOCK_ERR;
            else if (rst_stuck)
               state_next = ST_RST_ERR2;
            else if (rst_rise)
               state_next = ST_OUT_DIS;
         end
         ST_OUT_DIS: begin
            if (!sync.permit)
               state_next = ST_SAFE;
            else if (entry_reg && sync.request && !static_opt && !req_rise)
               state_next = ST_CTL_ERR;
            else if (req_go)
               state_next = ST_OUT_EN;
         end
         ST_OUT_EN: begin
            if (!sync.permit)
               state_next = ST_SAFE;
            else if (!sync.request)
               state_next = ST_OUT_DIS;
         end
         ST_RST_ERR1, ST_INIT_ERR: begin
            if (!sync.reset)
               state_next = ST_INIT;
         end
         ST_RST_ERR2, ST_LOCK_ERR: begin
            if (!sync.reset)
               state_next = ST_LOCK;
         end
         ST_CTL_ERR: begin
            if (!sync.request)
               state_next = ST_OUT_DIS;
         end
         default: state_next = ST_IDLE;
      endcase
      if (!enable)
         state_next = ST_IDLE;
   end

   // Diagnostic code per state
   always_comb begin
      case (state_next)
         ST_INIT:     diag_next = DIAG_INIT;
         ST_SAFE:     diag_next = DIAG_SAFE;
         ST_LOCK:     diag_next = DIAG_LOCK;
         ST_OUT_DIS:  diag_next = DIAG_OUT_DIS;
         ST_OUT_EN:   diag_next = DIAG_OUT_EN;
         ST_RST_ERR1: diag_next = DIAG_RST_ERR1;
         ST_RST_ERR2: diag_next = DIAG_RST_ERR2;
         ST_CTL_ERR:  diag_next = DIAG_CTL_ERR;
         ST_INIT_ERR: diag_next = DIAG_INIT_ERR;
         ST_LOCK_ERR: diag_next = DIAG_LOCK_ERR;
         default:     diag_next = DIAG_IDLE;
      endcase
   end

   wire err_next = diag_next[15] & diag_next[14];
   wire out_next = (state_next == ST_OUT_EN);

   // State and outputs, all registered so pins never glitch
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         state_reg         <= ST_IDLE;
         entry_reg         <= 1'b0;
         DIAGNOSTIC_CODE   <= DIAG_IDLE;
         SAFE_ACTUATOR_OUT <= 1'b0;
         READY             <= 1'b0;
         ERROR             <= 1'b0;
      end else begin
         state_reg         <= state_next;
         entry_reg         <= (state_next != state_reg);
         DIAGNOSTIC_CODE   <= diag_next;
         SAFE_ACTUATOR_OUT <= out_next;
         READY             <= (state_next != ST_IDLE);
         ERROR             <= err_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Interrupt events; set wins over clear
   wire [2:0] ev = {SAFE_ACTUATOR_OUT & ~out_next,
                    ~SAFE_ACTUATOR_OUT & out_next,
                    ~ERROR & err_next};
   wire       w_fire  = aw_got & w_got & ~BVALID;
   wire       wr_clr  = w_fire & (aw_addr_reg == OFS_IRQ_CL) & w_strb_reg[0];
   assign irq_st_next = ev | (irq_st_reg & ~(wr_clr ? w_data_reg[2:0] : 3'h0));

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         irq_st_reg <= 3'h0;
         IRQ        <= 1'b0;
      end else begin
         irq_st_reg <= irq_st_next;
         IRQ        <= |(irq_st_next & irq_en_reg);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // AXI4-Lite write side: address and data latched in either order
   wire aw_hit = (aw_addr_reg == OFS_CTRL) || (aw_addr_reg == OFS_IRQ_EN)
                 || (aw_addr_reg == OFS_IRQ_CL);
   // Ready flops double as the holding flags, so no second copy of state
   assign aw_got  = ~AWREADY;
   assign w_got   = ~WREADY;

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         AWREADY     <= 1'b1;
         WREADY      <= 1'b1;
         aw_addr_reg <= 4'h0;
         w_data_reg  <= 32'h0000_0000;
         w_strb_reg  <= 4'h0;
         BVALID      <= 1'b0;
         BRESP       <= RESP_OKAY;
      end else begin
         if (AWVALID && AWREADY) begin
            AWREADY     <= 1'b0;
            aw_addr_reg <= AWADDR;
         end
         if (WVALID && WREADY) begin
            WREADY     <= 1'b0;
            w_data_reg <= WDATA;
            w_strb_reg <= WSTRB;
         end
         if (w_fire) begin
            BVALID <= 1'b1;
            BRESP  <= aw_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (BVALID && BREADY) begin
            BVALID  <= 1'b0;
            AWREADY <= 1'b1;
            WREADY  <= 1'b1;
         end
      end
   end

   // Writable registers
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         ctrl_reg   <= CTRL_RESET_VAL;
         irq_en_reg <= 3'h0;
      end else if (w_fire && w_strb_reg[0]) begin
         if (aw_addr_reg == OFS_CTRL)
            ctrl_reg <= w_data_reg[3:0];
         else if (aw_addr_reg == OFS_IRQ_EN)
            irq_en_reg <= w_data_reg[2:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // AXI4-Lite read side, one cycle answer
   wire [31:0] rd_mux =
      (ARADDR == OFS_CTRL)   ? {28'h0, ctrl_reg} :
      (ARADDR == OFS_STATUS) ? {13'h0, ERROR, READY, SAFE_ACTUATOR_OUT,
                                DIAGNOSTIC_CODE} :
      (ARADDR == OFS_IRQ_ST) ? {29'h0, irq_st_reg} :
      (ARADDR == OFS_IRQ_EN) ? {29'h0, irq_en_reg} : 32'h0000_0000;
   wire rd_hit = (ARADDR == OFS_CTRL) || (ARADDR == OFS_STATUS)
                 || (ARADDR == OFS_IRQ_ST) || (ARADDR == OFS_IRQ_EN);

   // ARREADY is a flop so the pin never glitches with the read mux
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         RVALID  <= 1'b0;
         ARREADY <= 1'b1;
         RDATA   <= 32'h0000_0000;
         RRESP   <= RESP_OKAY;
      end else if (ARVALID && ARREADY) begin
         RVALID  <= 1'b1;
         ARREADY <= 1'b0;
         RDATA   <= rd_mux;
         RRESP   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (RVALID && RREADY) begin
         RVALID  <= 1'b0;
         ARREADY <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   err_out_off_a: assert property (@(posedge CORE_CLK) disable iff (RST)
      ERROR |-> !SAFE_ACTUATOR_OUT)
      else $error("Output on during error");
   enable_idle_a: assert property (@(posedge CORE_CLK) disable iff (RST)
      !enable |=> state_reg == ST_IDLE && DIAGNOSTIC_CODE == DIAG_IDLE)
      else $error("Disable did not reach idle");
   rst_err_hold_a: assert property (@(posedge CORE_CLK) disable iff (RST)
      (state_reg == ST_RST_ERR1 && sync.reset && enable)
      |=> state_reg == ST_RST_ERR1)
      else $error("Reset error left with reset high");
   ctl_err_hold_a: assert property (@(posedge CORE_CLK) disable iff (RST)
      (state_reg == ST_CTL_ERR && sync.request && enable)
      |=> state_reg == ST_CTL_ERR)
      else $error("Control error left with request high");
   init_err_a: assert property (@(posedge CORE_CLK) disable iff (RST)
      (state_reg == ST_INIT && both_rise && enable)
      |=> DIAGNOSTIC_CODE == DIAG_INIT_ERR && ERROR && READY)
      else $error("Init error code missing");
   lock_err_a: assert property (@(posedge CORE_CLK) disable iff (RST)
      (state_reg == ST_LOCK && sync.permit && both_rise && enable)
      |=> DIAGNOSTIC_CODE == DIAG_LOCK_ERR && ERROR)
      else $error("Lock error code missing");
   init_stuck_a: assert property (@(posedge CORE_CLK) disable iff (RST)
      (state_reg == ST_INIT && rst_stuck && enable)
      |=> DIAGNOSTIC_CODE == DIAG_RST_ERR1)
      else $error("Reset error 1 missing");
   lock_stuck_a: assert property (@(posedge CORE_CLK) disable iff (RST)
      (state_reg == ST_LOCK && sync.permit && rst_stuck && !both_rise
       && enable) |=> DIAGNOSTIC_CODE == DIAG_RST_ERR2)
      else $error("Reset error 2 missing");
   enter_init_a: assert property (@(posedge CORE_CLK) disable iff (RST)
      (state_reg == ST_IDLE && enable && !startup_clr)
      |=> DIAGNOSTIC_CODE == DIAG_INIT && READY && !SAFE_ACTUATOR_OUT)
      else $error("Init not entered");
   out_follows_a: assert property (@(posedge CORE_CLK) disable iff (RST)
      SAFE_ACTUATOR_OUT |-> DIAGNOSTIC_CODE == DIAG_OUT_EN)
      else $error("Output and code disagree");
   ctl_err_a: assert property (@(posedge CORE_CLK) disable iff (RST)
      (state_reg == ST_OUT_DIS && entry_reg && sync.permit && sync.request
       && !static_opt && !req_rise && enable)
      |=> DIAGNOSTIC_CODE == DIAG_CTL_ERR && ERROR && READY)
      else $error("Control error code missing");
   static_go_a: assert property (@(posedge CORE_CLK) disable iff (RST)
      (state_reg == ST_OUT_DIS && sync.permit && static_opt && sync.request
       && enable)
      |=> SAFE_ACTUATOR_OUT && DIAGNOSTIC_CODE == DIAG_OUT_EN)
      else $error("Static request did not enable output");
   lock_wait_a: assert property (@(posedge CORE_CLK) disable iff (RST)
      (state_reg == ST_SAFE && sync.permit && !auto_rst && enable)
      |=> DIAGNOSTIC_CODE == DIAG_LOCK && !SAFE_ACTUATOR_OUT)
      else $error("Lock not entered after permit");
   init_err_c: cover property (@(posedge CORE_CLK) state_reg == ST_INIT_ERR);
   ctl_err_c:  cover property (@(posedge CORE_CLK) state_reg == ST_CTL_ERR);
   lock_err_c: cover property (@(posedge CORE_CLK) state_reg == ST_LOCK_ERR);
   out_en_c:   cover property (@(posedge CORE_CLK) SAFE_ACTUATOR_OUT);

endmodule : sogate_top

// ### dv/sogate_partner.sv
`timescale 1ns/1ns
// Upstream safety and process logic that drives the gate pins
module sogate_partner (
   // Clock
   input  wire logic clk,
   // Gate pins
   output logic      permit,
   output logic      request,
   output logic      reset_pin
);
   // Permit up, request and reset low until told otherwise
   initial begin
      permit    = 1'b1;
      request   = 1'b0;
      reset_pin = 1'b0;
   end

   // New levels right after an edge, then held for a caller-chosen
   // number of cycles; a long hold models a slow upstream scan
   task automatic drive(input logic p, q, r, input int hold);
      @(posedge clk);
      permit    <= p;
      request   <= q;
      reset_pin <= r;
      repeat (hold) @(posedge clk);
   endtask : drive
endmodule : sogate_partner

// ### dv/safety_output_gate_errors_test.sv
`timescale 1ns/1ns
module safety_output_gate_errors_test import sogate_pkg::*;;
   logic        clk, rst, permit, request, reset_pin, out, rdy, err;
   logic        irq, awvalid, awready, wvalid, wready, bvalid;
   logic        arvalid, arready, rvalid;
   logic [1:0]  bresp, rresp;
   logic [3:0]  awaddr, araddr, wstrb;
   logic [15:0] code, last_code;
   logic [31:0] wdata, rdata;
   logic [18:0] st_q[$];
   logic [33:0] rd_q[$];
   logic [1:0]  wr_q[$];
   int          miscompares, n_compared, cycles, seed;

   sogate_partner sogate_partner_i (.clk(clk), .permit(permit),
      .request(request), .reset_pin(reset_pin));

   sogate_top sogate_top_i (.CORE_CLK(clk), .RST(rst),
      .SAFETY_PERMIT_IN(permit), .PROCESS_REQUEST(request),
      .RESET_IN(reset_pin), .SAFE_ACTUATOR_OUT(out), .READY(rdy),
      .ERROR(err), .DIAGNOSTIC_CODE(code), .IRQ(irq),
      .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
      .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready),
      .BRESP(bresp), .BVALID(bvalid), .BREADY(1'b1),
      .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
      .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(1'b1));

   ////////////////////////////////////////////////////////////
   // Mismatch bookkeeping shared by the compare tasks
   task automatic report(input bit ok, input logic [35:0] e, g);
      n_compared++;
      if (!ok) begin
         miscompares++;
         $display("[ERR] %0t exp %h got %h", $time, e, g);
      end
   endtask : report

   task automatic cmp_st(input logic [18:0] e, g);
      report(g === e, 36'(e), 36'(g));
   endtask : cmp_st

   task automatic cmp_rd(input logic [33:0] e, g);
      report(g === e, 36'(e), 36'(g));
   endtask : cmp_rd

   task automatic cmp_wr(input logic [1:0] e, g);
      report(g === e, 36'(e), 36'(g));
   endtask : cmp_wr

   task automatic cmp_irq(input logic e);
      report(irq === e, 36'(e), 36'(irq));
   endtask : cmp_irq

   task automatic end_sim();
      if (st_q.size() != 0 || rd_q.size() != 0 || wr_q.size() != 0)
         miscompares++;
      $display("compared %0d mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : end_sim

   // Outputs follow from the code: only Cxxx is an error
   task automatic expect_st(input logic [15:0] c);
      st_q.push_back({c[15:14] == 2'b11, c != 16'h0000,
                      c == DIAG_OUT_EN, c});
   endtask : expect_st

   // Pin change with a random settle time
   task automatic pins(input logic p, q, r);
      sogate_partner_i.drive(p, q, r, 8 + $urandom_range(3));
   endtask : pins

   // Control word: random upper bits must be ignored
   function automatic logic [31:0] ctl(input logic [3:0] b);
      return {28'($urandom()), b};
   endfunction : ctl

   // Address and data offered together, each dropped once taken
   task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
      // Only the three writable offsets answer OKAY
      wr_q.push_back((a == OFS_CTRL || a == OFS_IRQ_EN || a == OFS_IRQ_CL)
                     ? RESP_OKAY : RESP_SLVERR);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      do begin
         @(posedge clk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      repeat (6) @(posedge clk);
   endtask : axi_wr

   task automatic axi_rd(input logic [3:0] a, input logic [33:0] e);
      rd_q.push_back(e);
      araddr  <= a;
      arvalid <= 1'b1;
      do begin
         @(posedge clk);
         if (arready === 1'b1) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
   endtask : axi_rd

   ////////////////////////////////////////////////////////////
   // Free-running core clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Each new code or read beat retires the oldest note; a hang
   // is cut off well beyond the few hundred cycles the run needs
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (rst === 1'b0 && code !== last_code) begin
         last_code <= code;
         cmp_st(st_q.pop_front(), {err, rdy, out, code});
      end
      if (rvalid === 1'b1)
         cmp_rd(rd_q.pop_front(), {rresp, rdata});
      if (bvalid === 1'b1)
         cmp_wr(wr_q.pop_front(), bresp);
      if (cycles == 8000) begin
         miscompares++;
         end_sim();
      end
   end

   ////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      seed = $urandom(17272);
      {rst, awvalid, wvalid, arvalid} = 4'h8;
      {awaddr, araddr, wdata} = '0;
      wstrb = 4'hF;
      {last_code, miscompares, n_compared, cycles} = '0;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      axi_rd(OFS_STATUS, {RESP_OKAY, 32'h0000_0000});
      axi_rd(OFS_IRQ_ST, {RESP_OKAY, 32'h0000_0000});
      axi_rd(4'h2, {RESP_SLVERR, 32'h0000_0000});
      axi_wr(OFS_IRQ_EN, 32'h0000_0007);
      // Unmapped write errors out, strobe-less write changes nothing
      axi_wr(4'h2, 32'h0000_0000);
      wstrb <= 4'h0;
      axi_wr(OFS_IRQ_EN, 32'h0000_0000);
      wstrb <= 4'hF;
      axi_rd(OFS_IRQ_EN, {RESP_OKAY, 32'h0000_0007});
      $display("test registers done");
      expect_st(DIAG_INIT);
      axi_wr(OFS_CTRL, ctl(4'h1));
      expect_st(DIAG_OUT_DIS);
      pins(1'b1, 1'b0, 1'b1);
      pins(1'b1, 1'b0, 1'b0);
      expect_st(DIAG_OUT_EN);
      pins(1'b1, 1'b1, 1'b0);
      axi_rd(OFS_STATUS, {RESP_OKAY, 32'h0003_8000});
      $display("test normal start done");
      expect_st(DIAG_SAFE);
      pins(1'b0, 1'b1, 1'b0);
      pins(1'b0, 1'b1, 1'b1);
      expect_st(DIAG_LOCK);
      expect_st(DIAG_RST_ERR2);
      pins(1'b1, 1'b1, 1'b1);
      axi_rd(OFS_STATUS, {RESP_OKAY, 32'h0006_C002});
      expect_st(DIAG_LOCK);
      pins(1'b1, 1'b1, 1'b0);
      $display("test stuck reset in lock done");
      expect_st(DIAG_OUT_DIS);
      expect_st(DIAG_CTL_ERR);
      pins(1'b1, 1'b1, 1'b1);
      pins(1'b1, 1'b1, 1'b0);
      expect_st(DIAG_OUT_DIS);
      pins(1'b1, 1'b0, 1'b0);
      $display("test control error done");
      expect_st(DIAG_OUT_EN);
      pins(1'b1, 1'b1, 1'b0);
      expect_st(DIAG_SAFE);
      pins(1'b0, 1'b1, 1'b0);
      expect_st(DIAG_LOCK);
      pins(1'b1, 1'b0, 1'b0);
      expect_st(DIAG_LOCK_ERR);
      pins(1'b1, 1'b1, 1'b1);
      expect_st(DIAG_IDLE);
      axi_wr(OFS_CTRL, ctl(4'h0));
      pins(1'b1, 1'b0, 1'b0);
      $display("test lock error done");
      expect_st(DIAG_INIT);
      axi_wr(OFS_CTRL, ctl(4'h1));
      expect_st(DIAG_INIT_ERR);
      pins(1'b1, 1'b1, 1'b1);
      expect_st(DIAG_INIT);
      pins(1'b1, 1'b0, 1'b0);
      expect_st(DIAG_IDLE);
      axi_wr(OFS_CTRL, ctl(4'h0));
      pins(1'b1, 1'b0, 1'b1);
      expect_st(DIAG_INIT);
      expect_st(DIAG_RST_ERR1);
      axi_wr(OFS_CTRL, ctl(4'h1));
      expect_st(DIAG_INIT);
      pins(1'b1, 1'b0, 1'b0);
      $display("test init errors done");
      pins(1'b1, 1'b1, 1'b0);
      axi_wr(OFS_CTRL, ctl(4'h3));
      expect_st(DIAG_OUT_DIS);
      expect_st(DIAG_OUT_EN);
      pins(1'b1, 1'b1, 1'b1);
      pins(1'b1, 1'b1, 1'b0);
      $display("test static request done");
      cmp_irq(1'b1);
      axi_rd(OFS_IRQ_ST, {RESP_OKAY, 32'h0000_0007});
      axi_wr(OFS_IRQ_EN, 32'h0000_0000);
      cmp_irq(1'b0);
      axi_wr(OFS_IRQ_CL, 32'h0000_0007);
      axi_rd(OFS_IRQ_ST, {RESP_OKAY, 32'h0000_0000});
      axi_wr(OFS_IRQ_EN, 32'h0000_0007);
      cmp_irq(1'b0);
      expect_st(DIAG_SAFE);
      pins(1'b0, 1'b1, 1'b0);
      cmp_irq(1'b1);
      axi_rd(OFS_IRQ_ST, {RESP_OKAY, 32'h0000_0004});
      $display("test interrupts done");
      repeat (4) @(posedge clk);
      end_sim();
   end
endmodule : safety_output_gate_errors_test
